// ===== rtl/evd_dispatch.sv
// exception and interrupt vector dispatcher, top level
`timescale 1ns/1ps
`include "evd_defines.svh"
module evd_dispatch
   import evd_pkg::*;
#(
   parameter int VW = `EVD_VEC_W,
   parameter int EW = 32
) (
   // clock and reset
   input  wire logic          sys_clk,
   input  wire logic          nrst,
   // local interrupt pins and controller setup
   input  wire logic [1:0]    local_irq_pins,
   input  wire logic          lapicEnable,
   input  wire logic [VW-1:0] lvtVector0,
   input  wire logic [VW-1:0] lvtVector1,
   input  wire logic [1:0]    lvtMask,
   input  wire logic          ifFlag,
   // core exception requests, held until evtTaken
   input  wire logic          divide_error_fault,
   input  wire logic          invalid_opcode_fault,
   input  wire logic          double_fault_abort,
   input  wire logic          bad_task_state_fault,
   input  wire logic          segment_absent_fault,
   input  wire logic          stackFault,
   input  wire logic          protection_fault,
   input  wire logic          page_translation_fault,
   input  wire logic [EW-1:0] excErrCode,
   // software interrupt request
   input  wire logic          swIntReq,
   input  wire logic [VW-1:0] swIntVector,
   // system bus vector read
   output logic               vecReadReq,
   input  wire logic          busVecValid,
   input  wire logic [VW-1:0] busVector,
   // handler descriptor table read
   output logic               tableRdReq,
   output logic [VW-1:0]      tableIndex,
   input  wire logic          tableValid,
   input  wire logic [EW-1:0] tableEntry,
   // task control
   input  wire logic          handlerDone,
   input  wire logic          recoverable,
   output logic               evtTaken,
   output logic               handlerStart,
   output logic [EW-1:0]      handlerEntry,
   output logic               taskSuspended,
   output logic               taskResume,
   output logic               taskAbort,
   // dispatch report
   output logic [VW-1:0]      dispVector,
   output evd_class_t         dispClass,
   output logic               dispPushErr,
   output logic [EW-1:0]      dispErrCode,
   output evd_src_t           dispSrc,
   output logic               nmiInService,
   output logic               illegalVector
);
   typedef struct packed {
      evd_state_t    state;
      logic [1:0]    pinPrev;
      logic [1:0]    lintPend;
      logic          nmiPend;
      logic          vecReadReq;
      logic          tableRdReq;
      logic [VW-1:0] tableIndex;
      logic          evtTaken;
      logic          handlerStart;
      logic [EW-1:0] handlerEntry;
      logic          taskSuspended;
      logic          taskResume;
      logic          taskAbort;
      logic [VW-1:0] dispVector;
      evd_class_t    dispClass;
      logic          dispPushErr;
      logic [EW-1:0] dispErrCode;
      evd_src_t      dispSrc;
      logic          nmiInService;
      logic          illegalVector;
   } evd_regs_t;

   evd_regs_t  r;
   evd_regs_t  next_r;
   logic [1:0] rstStage;
   logic       rstSyncN;
   logic [1:0] pinSync;
   logic [1:0] pinRise;
   logic [7:0] excReq;
   evd_class_t lkClass;
   logic       lkPushErr;

   // reset release through two flops
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rstStage <= 2'h0;
      end else begin
         rstStage <= {rstStage[0], 1'b1};
      end
   end
   assign rstSyncN = rstStage[1];

   evd_pin_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .sys_clk  (sys_clk),
      .rstSyncN (rstSyncN),
      .pinIn    (local_irq_pins),
      .pinSync  (pinSync)
   );

   evd_vec_class u_vec_class (
      .vector     (r.dispVector),
      .vecClass   (lkClass),
      .pushesErr  (lkPushErr),
      .archVector ()
   );

   // rising edges and exception requests in priority order
   assign pinRise = pinSync & ~r.pinPrev;
   assign excReq  = {divide_error_fault, invalid_opcode_fault, bad_task_state_fault, segment_absent_fault,
                     stackFault, protection_fault, page_translation_fault, double_fault_abort};

   // vector of the highest-priority exception request
   function automatic logic [VW-1:0] excVector(input logic [7:0] req);
      logic [VW-1:0] v;
      v = `EVD_VEC_DIVIDE;
      if (req[7]) v = `EVD_VEC_DIVIDE;
      if (req[6]) v = `EVD_VEC_INVOP;
      if (req[5]) v = `EVD_VEC_BADTSS;
      if (req[4]) v = `EVD_VEC_ABSENT;
      if (req[3]) v = `EVD_VEC_STACK;
      if (req[2]) v = `EVD_VEC_PROTECT;
      if (req[1]) v = `EVD_VEC_PAGE;
      if (req[0]) v = `EVD_VEC_DOUBLE;
      return v;
   endfunction

   // next-state logic
   always_comb begin
      next_r               = r;
      next_r.pinPrev       = pinSync;
      next_r.evtTaken      = 1'b0;
      next_r.handlerStart  = 1'b0;
      next_r.taskResume    = 1'b0;
      next_r.illegalVector = 1'b0;
      case (r.state)
         EVD_IDLE: begin
            if (|excReq) begin
               next_r.dispVector  = excVector(excReq);
               next_r.dispSrc     = EVD_SRC_EXC;
               next_r.dispErrCode = double_fault_abort ? `EVD_ERR_ZERO : excErrCode;
               next_r.evtTaken    = 1'b1;
               next_r.state       = EVD_FETCH;
            end else if (r.nmiPend && !r.nmiInService) begin
               next_r.dispVector   = `EVD_VEC_NMI;
               next_r.dispSrc      = EVD_SRC_NMI;
               next_r.nmiPend      = 1'b0;
               next_r.nmiInService = 1'b1;
               next_r.state        = EVD_FETCH;
            end else if (lapicEnable && r.lintPend[0]) begin
               next_r.dispVector  = lvtVector0;
               next_r.dispSrc     = EVD_SRC_LINT;
               next_r.lintPend[0] = 1'b0;
               next_r.state       = EVD_FETCH;
            end else if (lapicEnable && r.lintPend[1]) begin
               next_r.dispVector  = lvtVector1;
               next_r.dispSrc     = EVD_SRC_LINT;
               next_r.lintPend[1] = 1'b0;
               next_r.state       = EVD_FETCH;
            end else if (!lapicEnable && pinSync[0] && ifFlag) begin
               next_r.vecReadReq = 1'b1;
               next_r.dispSrc    = EVD_SRC_BUS;
               next_r.state      = EVD_VECREAD;
            end else if (swIntReq) begin
               // software interrupts ignore the enable flag
               next_r.dispVector = swIntVector;
               next_r.dispSrc    = EVD_SRC_SW;
               next_r.evtTaken   = 1'b1;
               next_r.state      = EVD_FETCH;
            end
            next_r.tableRdReq = (next_r.state == EVD_FETCH);
            next_r.tableIndex = next_r.dispVector;
         end
         EVD_VECREAD: begin
            // vector taken from the system bus
            if (busVecValid) begin
               next_r.vecReadReq = 1'b0;
               next_r.dispVector = busVector;
               next_r.tableIndex = busVector;
               next_r.tableRdReq = 1'b1;
               next_r.state      = EVD_FETCH;
            end
         end
         EVD_FETCH: begin
            if (tableValid) begin
               next_r.tableRdReq    = 1'b0;
               next_r.handlerEntry  = tableEntry;
               next_r.handlerStart  = 1'b1;
               next_r.taskSuspended = 1'b1;
               next_r.dispClass     = (r.dispSrc == EVD_SRC_EXC) ? lkClass : EVD_CLS_MASKABLE_IRQ_PIN;
               // software and interrupts push no code
               next_r.dispPushErr   = (r.dispSrc == EVD_SRC_EXC) && lkPushErr;
               next_r.state         = EVD_RUN;
            end
         end
         EVD_RUN: begin
            // resume or abort at handler end
            if (handlerDone) begin
               next_r.taskSuspended = 1'b0;
               next_r.nmiInService  = 1'b0;
               if (recoverable) begin
                  next_r.taskResume = 1'b1;
                  next_r.state      = EVD_IDLE;
               end else begin
                  next_r.taskAbort = 1'b1;
                  next_r.state     = EVD_HALT;
               end
            end
         end
         EVD_HALT: begin
            next_r.taskAbort = 1'b1;
         end
         default: begin
            next_r.state = EVD_IDLE;
         end
      endcase
      // with the controller off, a pin 1 edge latches a non-maskable request, set wins
      if (!lapicEnable && pinRise[1]) begin
         next_r.nmiPend = 1'b1;
      end
      // programmed vectors below 16 are rejected
      if (lapicEnable && pinRise[0] && !lvtMask[0]) begin
         if (lvtVector0 < `EVD_VEC_LAPIC_LO) begin
            next_r.illegalVector = 1'b1;
         end else begin
            next_r.lintPend[0] = 1'b1;
         end
      end
      if (lapicEnable && pinRise[1] && !lvtMask[1]) begin
         if (lvtVector1 < `EVD_VEC_LAPIC_LO) begin
            next_r.illegalVector = 1'b1;
         end else begin
            next_r.lintPend[1] = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state register
   assign vecReadReq    = r.vecReadReq;
   assign tableRdReq    = r.tableRdReq;
   assign tableIndex    = r.tableIndex;
   assign evtTaken      = r.evtTaken;
   assign handlerStart  = r.handlerStart;
   assign handlerEntry  = r.handlerEntry;
   assign taskSuspended = r.taskSuspended;
   assign taskResume    = r.taskResume;
   assign taskAbort     = r.taskAbort;
   assign dispVector    = r.dispVector;
   assign dispClass     = r.dispClass;
   assign dispPushErr   = r.dispPushErr;
   assign dispErrCode   = r.dispErrCode;
   assign dispSrc       = r.dispSrc;
   assign nmiInService  = r.nmiInService;
   assign illegalVector = r.illegalVector;

   // checks on the dispatch behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstSyncN);

   a_double_zero: assert property (handlerStart && dispSrc == EVD_SRC_EXC && dispVector == `EVD_VEC_DOUBLE
      |-> dispPushErr && dispErrCode == `EVD_ERR_ZERO && dispClass == EVD_CLS_ABORT)
      else $error("double fault dispatch without zero code");
   a_nmi_vector: assert property ($rose(nmiInService) |-> dispVector == `EVD_VEC_NMI)
      else $error("non-maskable dispatch not on vector 2");
   a_sw_noerr: assert property (handlerStart && dispSrc == EVD_SRC_SW |-> !dispPushErr && !nmiInService)
      else $error("software interrupt pushed code or used nmi hardware");
   a_table_index: assert property ($rose(tableRdReq) |-> tableIndex == dispVector ##1 tableIndex == dispVector)
      else $error("table index differs from vector");
   a_suspend_run: assert property (handlerStart |-> taskSuspended && !tableRdReq)
      else $error("handler started without suspending task");
   a_resume_done: assert property (taskResume |-> $past(handlerDone) && $past(recoverable) && !taskSuspended)
      else $error("resume without recoverable handler end");
   a_bus_masked: assert property ($rose(vecReadReq) |-> $past(ifFlag) && !$past(lapicEnable))
      else $error("bus vector read while masked or controller enabled");
   a_no_reserved: assert property (handlerStart && dispSrc == EVD_SRC_EXC
      |-> dispVector != `EVD_VEC_OVERRUN && dispVector != `EVD_VEC_RSVD15)
      else $error("reserved vector generated by hardware");
   a_err_push: assert property (handlerStart && dispSrc == EVD_SRC_EXC && dispVector >= `EVD_VEC_BADTSS
      && dispVector <= `EVD_VEC_PAGE |-> dispPushErr)
      else $error("error code missing for fault with code");
   a_lint_legal: assert property (handlerStart && dispSrc == EVD_SRC_LINT |-> dispVector >= `EVD_VEC_LAPIC_LO)
      else $error("illegal local vector dispatched");

   c_nmi_path: cover property (handlerStart && dispSrc == EVD_SRC_NMI);
   c_bus_path: cover property (vecReadReq ##[1:20] handlerStart);
   c_sw_masked: cover property (handlerStart && dispSrc == EVD_SRC_SW && !ifFlag);
   c_abort: cover property ($rose(taskAbort));
endmodule

// ===== rtl/evd_defines.svh
// constants for the exception vector dispatcher
`ifndef EVD_DEFINES_SVH
`define EVD_DEFINES_SVH

`define EVD_VEC_W        8
`define EVD_VEC_DIVIDE   8'h00
`define EVD_VEC_NMI      8'h02
`define EVD_VEC_INVOP    8'h06
`define EVD_VEC_DOUBLE   8'h08
`define EVD_VEC_OVERRUN  8'h09
`define EVD_VEC_BADTSS   8'h0a
`define EVD_VEC_ABSENT   8'h0b
`define EVD_VEC_STACK    8'h0c
`define EVD_VEC_PROTECT  8'h0d
`define EVD_VEC_PAGE     8'h0e
`define EVD_VEC_RSVD15   8'h0f
`define EVD_VEC_LAPIC_LO 8'h10
`define EVD_VEC_ARCH_HI  8'h1f
`define EVD_VEC_USER_LO  8'h20
`define EVD_ERR_ZERO     32'h0000_0000

`endif

// ===== rtl/evd_pkg.sv
// types shared by the exception vector dispatcher
package evd_pkg;
   // dispatch sequence, gray coded along the bus vector path
   typedef enum logic [2:0] {
      EVD_IDLE    = 3'h0,
      EVD_VECREAD = 3'h1,
      EVD_FETCH   = 3'h3,
      EVD_RUN     = 3'h2,
      EVD_HALT    = 3'h6
   } evd_state_t;

   // exception class reported with each dispatch
   typedef enum logic [1:0] {
      EVD_CLS_FAULT = 2'h0,
      EVD_CLS_TRAP  = 2'h1,
      EVD_CLS_ABORT = 2'h2,
      EVD_CLS_MASKABLE_IRQ_PIN  = 2'h3
   } evd_class_t;

   // origin of the event being dispatched
   typedef enum logic [2:0] {
      EVD_SRC_EXC  = 3'h0,
      EVD_SRC_NMI  = 3'h1,
      EVD_SRC_LINT = 3'h2,
      EVD_SRC_BUS  = 3'h3,
      EVD_SRC_SW   = 3'h4
   } evd_src_t;
endpackage

// ===== rtl/evd_pin_sync.sv
// two-flop synchroniser for a group of pins
`timescale 1ns/1ps
module evd_pin_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rstSyncN,
   // pins in, synchronised levels out
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] pinSync
);
   logic [WIDTH-1:0] stage1;

   // per-bit double flop, first stage read only by the second
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rstSyncN) begin
         if (!rstSyncN) begin
            stage1[i]  <= 1'b0;
            pinSync[i] <= 1'b0;
         end else begin
            stage1[i]  <= pinIn[i];
            pinSync[i] <= stage1[i];
         end
      end
   end
endmodule

// ===== rtl/evd_vec_class.sv
// class and error-code lookup for an architecture vector
`timescale 1ns/1ps
`include "evd_defines.svh"
module evd_vec_class
   import evd_pkg::*;
(
   // vector in
   input  wire logic [`EVD_VEC_W-1:0] vector,
   // classification out
   output evd_class_t                 vecClass,
   output logic                       pushesErr,
   output logic                       archVector
);
   // fixed lookup over the architecture span
   always_comb begin
      vecClass   = EVD_CLS_FAULT;
      pushesErr  = 1'b0;
      archVector = (vector <= `EVD_VEC_ARCH_HI);
      case (vector)
         `EVD_VEC_NMI:    vecClass = EVD_CLS_MASKABLE_IRQ_PIN;
         8'h03, 8'h04:    vecClass = EVD_CLS_TRAP;
         `EVD_VEC_DOUBLE: begin
            vecClass  = EVD_CLS_ABORT;
            pushesErr = 1'b1;
         end
         `EVD_VEC_BADTSS, `EVD_VEC_ABSENT, `EVD_VEC_STACK, `EVD_VEC_PROTECT, `EVD_VEC_PAGE: begin
            pushesErr = 1'b1;
         end
         `EVD_VEC_OVERRUN, `EVD_VEC_RSVD15: pushesErr = 1'b0;
         default: begin
            if (!archVector) begin
               vecClass = EVD_CLS_MASKABLE_IRQ_PIN;
            end
         end
      endcase
   end
endmodule

// ===== testbench/evd_far_model.sv
// far-side model: vector-supplying controller and descriptor table
`timescale 1ns/1ps
module evd_far_model (
   // clock
   input  wire logic        sys_clk,
   // system bus vector read
   input  wire logic        vecReadReq,
   input  wire logic [7:0]  ctlVector,
   input  wire logic        slow,
   output logic             busVecValid = 1'b0,
   output logic [7:0]       busVector = 8'h5a,
   // descriptor table read
   input  wire logic        tableRdReq,
   input  wire logic [7:0]  tableIndex,
   output logic             tableValid = 1'b0,
   output logic [31:0]      tableEntry = 32'h0
);
   logic [3:0] busCnt = 4'h0;
   logic [3:0] tabCnt = 4'h0;
   logic       busDone = 1'b0;
   logic       tabDone = 1'b0;
   logic [3:0] lat;

   // slow mode answers four cycles later
   assign lat = slow ? 4'h4 : 4'h0;

   // one answer per request; released lines toggle so stale data never matches
   always @(posedge sys_clk) begin
      busVecValid <= 1'b0;
      tableValid  <= 1'b0;
      busVector   <= ~busVector;
      tableEntry  <= ~tableEntry;
      busCnt      <= (vecReadReq && !busDone) ? busCnt + 4'h1 : 4'h0;
      tabCnt      <= (tableRdReq && !tabDone) ? tabCnt + 4'h1 : 4'h0;
      busDone     <= vecReadReq && (busDone || busCnt == lat);
      tabDone     <= tableRdReq && (tabDone || tabCnt == lat);
      if (vecReadReq && !busDone && busCnt == lat) begin
         busVecValid <= 1'b1;
         busVector   <= ctlVector;
      end
      if (tableRdReq && !tabDone && tabCnt == lat) begin
         tableValid <= 1'b1;
         tableEntry <= 32'h0000_1000 + {21'h0, tableIndex, 3'h0};
      end
   end
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the exception vector dispatcher
`timescale 1ns/1ps
module tb_top
   import evd_pkg::*;
();
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [1:0]  localIrqPins = 2'h0;
   logic        lapicEnable = 1'b0;
   logic [7:0]  lvtVector0 = 8'h30;
   logic [7:0]  lvtVector1 = 8'h31;
   logic [1:0]  lvtMask = 2'h0;
   logic        ifFlag = 1'b0;
   logic [7:0]  excReq = 8'h0;
   logic [31:0] excErrCode = 32'h0;
   logic        swIntReq = 1'b0;
   logic [7:0]  swIntVector = 8'h0;
   logic        handlerDone = 1'b0;
   logic        recoverable = 1'b1;
   logic [7:0]  ctlVector = 8'h40;
   logic        slow = 1'b0;
   logic        vecReadReq, busVecValid, tableRdReq, tableValid, evtTaken, handlerStart;
   logic        taskSuspended, taskResume, taskAbort, dispPushErr, nmiInService, illegalVector;
   logic [7:0]  busVector, tableIndex, dispVector;
   logic [31:0] tableEntry, handlerEntry, dispErrCode;
   evd_class_t  dispClass;
   evd_src_t    dispSrc;
   int          miscompares = 0;
   int          samplesChecked = 0;
   int          cycles = 0;

   evd_dispatch dut (
      .sys_clk, .nrst, .local_irq_pins(localIrqPins), .lapicEnable, .lvtVector0, .lvtVector1,
      .lvtMask, .ifFlag, .divide_error_fault(excReq[0]), .invalid_opcode_fault(excReq[1]),
      .double_fault_abort(excReq[2]), .bad_task_state_fault(excReq[3]), .segment_absent_fault(excReq[4]),
      .stackFault(excReq[5]), .protection_fault(excReq[6]), .page_translation_fault(excReq[7]),
      .excErrCode, .swIntReq, .swIntVector, .vecReadReq, .busVecValid, .busVector, .tableRdReq,
      .tableIndex, .tableValid, .tableEntry, .handlerDone, .recoverable, .evtTaken, .handlerStart,
      .handlerEntry, .taskSuspended, .taskResume, .taskAbort, .dispVector, .dispClass, .dispPushErr,
      .dispErrCode, .dispSrc, .nmiInService, .illegalVector
   );

   evd_far_model far (
      .sys_clk, .vecReadReq, .ctlVector, .slow, .busVecValid, .busVector,
      .tableRdReq, .tableIndex, .tableValid, .tableEntry
   );

   // 40 MHz clock
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   // step to just after a rising edge
   task automatic cyc(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic err(input string m);
      miscompares++;
      $display("Error at %0t: %s", $time, m);
   endtask

   function automatic bit ne(input logic [31:0] a, b);
      samplesChecked++;
      return a !== b;
   endfunction

   // verdict and end of run
   task automatic testDone();
      $display("checks %0d, mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 6000) begin
         err("run too long");
         testDone();
      end
   end

   // requests are held until the block takes them
   always @(posedge sys_clk) begin
      #1;
      if (evtTaken === 1'b1) begin
         excReq = 8'h0;
         swIntReq = 1'b0;
      end
   end

   // wait for the handler, judge the dispatch, then end the handler
   task automatic serve(input logic [7:0] v, input evd_class_t c, input logic p,
                        input logic [31:0] e, input evd_src_t s, input logic rec);
      int n;
      n = 0;
      while (handlerStart !== 1'b1 && n < 40) begin
         cyc();
         n++;
      end
      if (ne(handlerStart, 1)) err("handler never started");
      if (ne(tableIndex, v)) err("table index");
      if (ne(handlerEntry, 32'h1000 + 32'(v) * 8)) err("handler entry");
      if (ne(dispVector, v)) err("vector");
      if (ne(dispClass, c)) err("class");
      if (ne(dispPushErr, p)) err("error code push");
      if (p && ne(dispErrCode, e)) err("error code");
      if (ne(dispSrc, s)) err("source");
      if (ne(nmiInService, s == EVD_SRC_NMI)) err("nmi service");
      if (ne(taskSuspended, 1)) err("not suspended");
      cyc(3);
      recoverable = rec;
      handlerDone = 1'b1;
      cyc();
      handlerDone = 1'b0;
      if (ne(taskResume, rec)) err("resume");
      if (ne(taskAbort, !rec)) err("abort");
   endtask

   // every core exception on its own vector, class and code
   task automatic tExceptions();
      logic [7:0] vt [8];
      vt = '{8'h00, 8'h06, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
      for (int i = 0; i < 8; i++) begin
         excErrCode = 32'h0000_0a50 + i;
         excReq = 8'h1 << i;
         cyc();
         if (ne(evtTaken, 1)) err("exception not taken");
         serve(vt[i], vt[i] == 8'h08 ? EVD_CLS_ABORT : EVD_CLS_FAULT, vt[i] >= 8'h08,
               vt[i] == 8'h08 ? 32'h0 : excErrCode, EVD_SRC_EXC, 1'b1);
         cyc(2);
      end
   endtask

   // software vectors with the enable flag low, never an error code
   task automatic tSoftware();
      logic [7:0] vt [5];
      vt = '{8'h02, 8'h0d, 8'h09, 8'h0f, 8'hff};
      ifFlag = 1'b0;
      for (int i = 0; i < 5; i++) begin
         swIntVector = vt[i];
         swIntReq = 1'b1;
         cyc();
         if (ne(evtTaken, 1)) err("software request not taken");
         serve(vt[i], EVD_CLS_MASKABLE_IRQ_PIN, 1'b0, 32'h0, EVD_SRC_SW, 1'b1);
         cyc(2);
      end
   endtask

   // pin 1 as non-maskable input with the controller off
   task automatic tNmiPin();
      lapicEnable = 1'b0;
      localIrqPins = 2'b10;
      serve(8'h02, EVD_CLS_MASKABLE_IRQ_PIN, 1'b0, 32'h0, EVD_SRC_NMI, 1'b1);
      localIrqPins = 2'b00;
      cyc(2);
   endtask

   // pin 0 reads its vector from the bus, only with the flag set
   task automatic tBusVector();
      int n;
      n = 0;
      localIrqPins = 2'b01;
      cyc(8);
      if (ne(vecReadReq | taskSuspended, 0)) err("masked pin served");
      ifFlag = 1'b1;
      slow = 1'b1;
      ctlVector = 8'h40;
      while (vecReadReq !== 1'b1 && n < 20) begin
         cyc();
         n++;
      end
      localIrqPins = 2'b00;
      serve(8'h40, EVD_CLS_MASKABLE_IRQ_PIN, 1'b0, 32'h0, EVD_SRC_BUS, 1'b1);
      ifFlag = 1'b0;
      slow = 1'b0;
   endtask

   // controller on: programmed vectors, masking, illegal low vectors
   task automatic tLocalPins();
      int n;
      n = 0;
      lapicEnable = 1'b1;
      lvtVector1 = 8'h05;
      lvtMask = 2'b01;
      localIrqPins = 2'b01;
      cyc(8);
      if (ne(taskSuspended, 0)) err("masked pin dispatched");
      localIrqPins = 2'b00;
      lvtMask = 2'b00;
      cyc(2);
      localIrqPins = 2'b01;
      serve(8'h30, EVD_CLS_MASKABLE_IRQ_PIN, 1'b0, 32'h0, EVD_SRC_LINT, 1'b1);
      localIrqPins = 2'b10;
      while (illegalVector !== 1'b1 && n < 10) begin
         cyc();
         n++;
      end
      if (ne(illegalVector, 1)) err("illegal vector not flagged");
      cyc(8);
      if (ne(taskSuspended, 0)) err("illegal vector dispatched");
      localIrqPins = 2'b00;
      lapicEnable = 1'b0;
   endtask

   // unrecoverable end stops the block
   task automatic tAbort();
      excReq = 8'h01;
      serve(8'h00, EVD_CLS_FAULT, 1'b0, 32'h0, EVD_SRC_EXC, 1'b0);
      swIntVector = 8'h21;
      swIntReq = 1'b1;
      cyc(10);
      if (ne(taskSuspended | tableRdReq, 0)) err("dispatch after abort");
      swIntReq = 1'b0;
   endtask

   // reset, then the scenarios
   initial begin
      cyc(6);
      nrst = 1'b1;
      cyc(5);
      tExceptions();
      tSoftware();
      tNmiPin();
      tBusVector();
      tLocalPins();
      tAbort();
      testDone();
   end
endmodule
